// ===== verilog/fnl_pkg.sv
// Constants for the second fan speed table entry: offsets, resets, fields.
// Assumes an 8-bit register address space shared with other table entries.
package fnl_pkg;
  // Register offsets
  localparam logic [7:0] FNL_OFS_LIMIT = 8'h52;
  localparam logic [7:0] FNL_OFS_DUTY = 8'h53;
  // Reset values
  localparam logic [7:0] FNL_RST_LIMIT = 8'h7F;
  localparam logic [7:0] FNL_RST_DUTY = 8'h3F;
  // Field positions
  localparam int FNL_LIMIT_HIGH_BIT = 7;
  localparam int FNL_DUTY_EXT_LSB = 6;
  localparam int FNL_DUTY_BASE_W = 6;
  // Masks applied in low-resolution modes
  localparam logic [7:0] FNL_LIMIT_LOW_MASK = 8'h7F;
  localparam logic [7:0] FNL_DUTY_LOW_MASK = 8'h3F;
  // Widths of temperature data in half-degree units
  localparam int FNL_TEMP_W = 9;
  localparam int FNL_CMP_W = 11;
  // Largest hysteresis in whole degrees
  localparam logic [4:0] FNL_HYST_MAX = 5'h1F;
  // Read value of an address outside this entry
  localparam logic [7:0] FNL_RD_UNMAPPED = 8'h00;
endpackage : fnl_pkg

// ===== verilog/fnl_limit_cmp.sv
// Limit comparator with hysteresis for one fan speed table entry.
// Assumes all inputs are synchronous to clk and in half-degree units.
module fnl_limit_cmp #(
  parameter int CMP_W = fnl_pkg::FNL_CMP_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Values to compare
  input wire logic [CMP_W-1:0] temp_val,
  input wire logic [CMP_W-1:0] limit_val,
  input wire logic [CMP_W-1:0] hyst_val,
  // Result
  output logic exceeded_reg
);
  import fnl_pkg::*;

  // Limit plus doubled offset needs at least ten bits
  if (CMP_W < 10)
  begin : g_width_check
    $error("fnl_limit_cmp: CMP_W too narrow for limit plus offset");
  end

  logic exceeded_next;
  logic above_limit;
  logic below_release;
  logic [CMP_W:0] release_sum;

  // Release point sits hysteresis below the limit; sum avoids underflow
  assign release_sum = {1'b0, temp_val} + {1'b0, hyst_val};
  assign above_limit = temp_val > limit_val;
  assign below_release = release_sum <= {1'b0, limit_val};
  assign exceeded_next = exceeded_reg ? !below_release : above_limit;

  // Entry state, cleared by reset or once temperature has fallen far enough
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      exceeded_reg <= 1'b0;
    else
      exceeded_reg <= exceeded_next;
  end
endmodule // fnl_limit_cmp

// ===== verilog/fnl_duty_sel.sv
// Duty selection for one link in the fan speed table priority chain.
// Assumes the neighbouring entries feed their state in the same clock.
module fnl_duty_sel (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Reset value of the selected duty
  input wire logic [7:0] reset_duty,
  // Higher entry
  input wire logic higher_active,
  input wire logic [7:0] higher_duty,
  // This entry
  input wire logic own_active,
  input wire logic [7:0] own_duty,
  // Lower entry
  input wire logic [7:0] lower_duty,
  // Result
  output logic [7:0] duty_reg,
  output logic chain_active
);
  import fnl_pkg::*;

  logic [7:0] duty_next;

  // Highest exceeded entry wins, else fall back to the lower entry
  assign duty_next = higher_active ? higher_duty :
                     own_active ? own_duty : lower_duty;
  assign chain_active = higher_active | own_active;

  // Registered so the PWM generator never sees a glitching value
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      duty_reg <= reset_duty;
    else
      duty_reg <= duty_next;
  end

endmodule // fnl_duty_sel

// ===== verilog/fnl_entry.sv
// Second entry of the fan speed table: limit and duty registers, mode
// handling, comparison against remote temperature and duty selection.
// Assumes the host register port, mode bits, temperature reading and
// neighbouring entries all come from logic on the same clock.

module fnl_entry (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  output logic [7:0] reg_rd_data,
  output logic reg_hit,
  // Mode and control bits held elsewhere
  input wire logic table_write_enable,
  input wire logic temp_table_high_res,
  input wire logic duty_table_high_res,
  input wire logic pwm_freq_22k5,
  input wire logic [7:0] table_temp_offset,
  input wire logic [4:0] table_hysteresis_value,
  // Remote temperature, whole degrees and fraction
  input wire logic [7:0] remote_temp_int,
  input wire logic [2:0] remote_temp_frac,
  // Neighbouring entries in the table
  input wire logic higher_active,
  input wire logic [7:0] higher_duty,
  input wire logic [7:0] lower_duty,
  // Outputs toward the PWM generator and the next entry
  output logic [7:0] pwm_duty,
  output logic entry_exceeded,
  output logic chain_active
);
  import fnl_pkg::*;

  // Stored registers
  logic [7:0] limit_reg;
  logic [7:0] limit_next;
  logic [7:0] duty_reg;
  logic [7:0] duty_next;
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;

  // Decode and mode wires
  logic hit_limit;
  logic hit_duty;
  logic wr_limit;
  logic wr_duty;
  logic duty_ext_active;
  logic [7:0] limit_mask;
  logic [7:0] duty_mask;
  logic [7:0] limit_view;
  logic [7:0] duty_view;
  logic [7:0] eff_duty;
  logic [FNL_TEMP_W-1:0] temp_half;
  logic [FNL_CMP_W-1:0] temp_cmp;
  logic [FNL_CMP_W-1:0] limit_cmp;
  logic [FNL_CMP_W-1:0] offset_cmp;
  logic [FNL_CMP_W-1:0] hyst_cmp;
  logic [FNL_CMP_W-1:0] limit_base;
  logic exceeded;

  // Address match, shared by write and read paths
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] o);
    addr_is = (a == o);
  endfunction

  assign hit_limit = addr_is(reg_addr, FNL_OFS_LIMIT);
  assign hit_duty = addr_is(reg_addr, FNL_OFS_DUTY);
  assign reg_hit = hit_limit | hit_duty;

  // Writes are dropped silently while the table is locked
  assign wr_limit = reg_wr_en & hit_limit & table_write_enable;
  assign wr_duty = reg_wr_en & hit_duty & table_write_enable;

  // Mode masks; high-res keeps every bit (duty only at 22.5 kHz), low-res clears the top bits
  assign limit_mask = temp_table_high_res ? 8'hFF
                                          : FNL_LIMIT_LOW_MASK;
  assign duty_ext_active = duty_table_high_res & pwm_freq_22k5;
  assign duty_mask = duty_ext_active ? 8'hFF
                                     : FNL_DUTY_LOW_MASK;

  // Masked views; low-res stored bits are also cleared on write
  assign limit_view = limit_reg & limit_mask;
  assign duty_view = duty_reg & duty_mask;

  // Next values of the stored registers
  assign limit_next = wr_limit ? (reg_wr_data & limit_mask) : limit_reg;
  assign duty_next = wr_duty ? (reg_wr_data & duty_mask) : duty_reg;

  // Register storage
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      limit_reg <= FNL_RST_LIMIT;
      duty_reg <= FNL_RST_DUTY;
    end
    else
    begin
      limit_reg <= limit_next;
      duty_reg <= duty_next;
    end
  end

  // Readback one cycle after the address; unmapped reads give zero
  assign rd_data_next = hit_limit ? limit_view :
                        hit_duty ? duty_view : FNL_RD_UNMAPPED;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rd_data_reg <= FNL_RD_UNMAPPED;
    else
      rd_data_reg <= rd_data_next;
  end

  assign reg_rd_data = rd_data_reg;

  // Temperature in half degrees; low-res drops the half-degree bit
  assign temp_half = {remote_temp_int,
                      remote_temp_frac[2] & temp_table_high_res};
  assign temp_cmp = {2'b00, temp_half};

  // Limit in half degrees: high-res limit is already in halves, low-res
  // limit is whole degrees; sign is always taken as zero
  assign limit_base = temp_table_high_res
                      ? {3'b000, limit_view}
                      : {3'b000, limit_view[6:0], 1'b0};

  // Offset lifts the limit past 127 degrees without widening the field
  assign offset_cmp = {2'b00, table_temp_offset, 1'b0};
  assign limit_cmp = limit_base + offset_cmp;

  // Hysteresis in whole degrees, converted to halves
  assign hyst_cmp = {5'b00000, table_hysteresis_value, 1'b0};

  fnl_limit_cmp #(
    .CMP_W(FNL_CMP_W)
  ) u_cmp (
    .clk(clk),
    .rst_n(rst_n),
    .temp_val(temp_cmp),
    .limit_val(limit_cmp),
    .hyst_val(hyst_cmp),
    .exceeded_reg(exceeded)
  );

  assign entry_exceeded = exceeded;

  // Effective duty of this entry
  assign eff_duty = duty_view;

  fnl_duty_sel u_sel (
    .clk(clk),
    .rst_n(rst_n),
    .reset_duty(FNL_RST_DUTY),
    .higher_active(higher_active),
    .higher_duty(higher_duty),
    .own_active(exceeded),
    .own_duty(eff_duty),
    .lower_duty(lower_duty),
    .duty_reg(pwm_duty),
    .chain_active(chain_active)
  );

  // Checks
  chk_locked_limit_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    (reg_wr_en && hit_limit && !table_write_enable)
      |=> (limit_reg == $past(limit_reg)))
    else $error("limit changed while table locked");

  chk_locked_duty_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    (reg_wr_en && hit_duty && !table_write_enable)
      |=> (duty_reg == $past(duty_reg)))
    else $error("duty changed while table locked");

  chk_unlocked_write_lands: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wr_limit && temp_table_high_res)
      |=> (limit_reg == $past(reg_wr_data)))
    else $error("enabled limit write lost");

  chk_lowres_top_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!temp_table_high_res && hit_limit)
      |=> (reg_rd_data[FNL_LIMIT_HIGH_BIT] == 1'b0))
    else $error("limit bit 7 visible in low-res mode");

  chk_hires_limit_join: assert property (
    @(posedge clk) disable iff (!rst_n)
    temp_table_high_res |-> (limit_base == {3'b000, limit_reg}))
    else $error("high-res limit not joined");

  chk_lowres_temp_8bit: assert property (
    @(posedge clk) disable iff (!rst_n)
    !temp_table_high_res |-> (temp_cmp[0] == 1'b0))
    else $error("half-degree bit used in low-res mode");

  chk_offset_applied: assert property (
    @(posedge clk) disable iff (!rst_n)
    (limit_cmp - limit_base) == {2'b00, table_temp_offset, 1'b0})
    else $error("offset missing from limit");

  chk_exceed_sets: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!exceeded && temp_cmp > limit_cmp) |=> exceeded)
    else $error("entry not taken above limit");

  chk_hyst_holds: assert property (
    @(posedge clk) disable iff (!rst_n)
    (exceeded && (temp_cmp + hyst_cmp) > limit_cmp) |=> exceeded)
    else $error("entry released inside hysteresis band");

  chk_ext_bits_gated: assert property (
    @(posedge clk) disable iff (!rst_n)
    !pwm_freq_22k5 |-> (eff_duty[7:FNL_DUTY_EXT_LSB] == 2'b00))
    else $error("extended duty bits active off 22.5 kHz");

  chk_lowres_duty_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    !duty_table_high_res |-> (duty_view[7:FNL_DUTY_EXT_LSB] == 2'b00))
    else $error("extended duty bits set in low-res mode");

  chk_hires_duty_join: assert property (
    @(posedge clk) disable iff (!rst_n)
    duty_ext_active |-> (eff_duty == duty_reg))
    else $error("high-res duty not joined");

  chk_own_duty_out: assert property (
    @(posedge clk) disable iff (!rst_n)
    (exceeded && !higher_active) |=> (pwm_duty == $past(eff_duty)))
    else $error("paired duty not driven");

  chk_priority_chain: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!exceeded && !higher_active) |=> (pwm_duty == $past(lower_duty)))
    else $error("lower entry duty not kept");

  chk_higher_wins: assert property (
    @(posedge clk) disable iff (!rst_n)
    higher_active |=> (pwm_duty == $past(higher_duty)))
    else $error("higher entry did not win");

  chk_sign_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    limit_base[FNL_CMP_W-1:FNL_TEMP_W] == 2'b00)
    else $error("limit treated as signed");

  chk_unlocked_duty_lands: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wr_duty && duty_ext_active)
      |=> (duty_reg == $past(reg_wr_data)))
    else $error("enabled duty write lost");

  chk_lowres_limit_store: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wr_limit && !temp_table_high_res)
      |=> (limit_reg[FNL_LIMIT_HIGH_BIT] == 1'b0))
    else $error("limit bit 7 stored in low-res mode");

  chk_hires_temp_9bit: assert property (
    @(posedge clk) disable iff (!rst_n)
    temp_table_high_res |-> (temp_cmp[0] == remote_temp_frac[2]))
    else $error("half-degree bit lost in high-res mode");

  chk_release_below: assert property (
    @(posedge clk) disable iff (!rst_n)
    (exceeded && (temp_cmp + hyst_cmp) <= limit_cmp) |=> !exceeded)
    else $error("entry kept below the release point");

  chk_stay_below: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!exceeded && temp_cmp <= limit_cmp) |=> !exceeded)
    else $error("entry taken at or below limit");

  chk_lowres_duty_base: assert property (
    @(posedge clk) disable iff (!rst_n)
    !duty_ext_active
      |-> (eff_duty == {2'b00, duty_reg[FNL_DUTY_BASE_W-1:0]}))
    else $error("low-res duty not taken from bits 5:0");

  chk_chain_flag: assert property (
    @(posedge clk) disable iff (!rst_n)
    chain_active == (higher_active || exceeded))
    else $error("chain flag does not follow entry states");
endmodule // fnl_entry

// ===== test/fnl_entry_bench.sv
// Self-checking bench for the second fan speed table entry.
// Assumes the bench alone drives every port; no partner model.
module fnl_entry_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import fnl_pkg::*;

  typedef struct packed {
    logic thr;
    logic dhr;
    logic f22;
    logic [7:0] addr;
    logic [7:0] data;
    logic [7:0] exp;
    logic hit;
  } fnl_row_t;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr_en = 1'b0;
  logic [7:0] reg_wr_data = 8'h00;
  logic table_write_enable = 1'b0;
  logic thr = 1'b0;
  logic dhr = 1'b0;
  logic f22 = 1'b0;
  logic [7:0] ofs = 8'h00;
  logic [4:0] hyst = 5'h00;
  logic [7:0] t_int = 8'h00;
  logic [2:0] t_frac = 3'h0;
  logic hi_act = 1'b0;
  logic [7:0] hi_duty = 8'h00;
  logic [7:0] lo_duty = 8'h0A;
  logic [7:0] reg_rd_data;
  logic reg_hit;
  logic [7:0] pwm_duty;
  logic entry_exceeded;
  logic chain_active;
  int err_total = 0;
  int check_count = 0;
  fnl_row_t rows [6];

  // 100 MHz clock
  always #5 clk = ~clk;

  fnl_entry fnl_entry_inst (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .reg_hit(reg_hit), .table_write_enable(table_write_enable),
    .temp_table_high_res(thr), .duty_table_high_res(dhr),
    .pwm_freq_22k5(f22), .table_temp_offset(ofs),
    .table_hysteresis_value(hyst), .remote_temp_int(t_int),
    .remote_temp_frac(t_frac), .higher_active(hi_act),
    .higher_duty(hi_duty), .lower_duty(lo_duty), .pwm_duty(pwm_duty),
    .entry_exceeded(entry_exceeded), .chain_active(chain_active)
  );

  // Compare one value, count it, report a mismatch at once
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe, inputs changed at the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(negedge clk);
    reg_wr_en = 1'b0;
  endtask

  // Read data is registered, so it shows one edge after the address
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_addr = a;
    @(negedge clk);
    chk(reg_rd_data, exp);
  endtask

  // Comparator plus duty select take two edges; three leaves margin
  task automatic settle();
    repeat (3) @(negedge clk);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog: the tests need well under a thousand cycles
  initial
  begin
    #20000;
    err_total++;
    end_sim();
  end

  initial
  begin
    rows[0] = '{1'b1, 1'b0, 1'b0, FNL_OFS_LIMIT, 8'hA5, 8'hA5, 1'b1};
    rows[1] = '{1'b0, 1'b0, 1'b0, FNL_OFS_LIMIT, 8'hA5, 8'h25, 1'b1};
    rows[2] = '{1'b0, 1'b1, 1'b1, FNL_OFS_DUTY, 8'hC7, 8'hC7, 1'b1};
    rows[3] = '{1'b0, 1'b1, 1'b0, FNL_OFS_DUTY, 8'hC7, 8'h07, 1'b1};
    rows[4] = '{1'b0, 1'b0, 1'b1, FNL_OFS_DUTY, 8'hC7, 8'h07, 1'b1};
    rows[5] = '{1'b1, 1'b1, 1'b1, 8'h60, 8'hFF, FNL_RD_UNMAPPED, 1'b0};
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    // Reset values and refused write while locked
    chk(reg_rd_data, 8'h00);
    chk(pwm_duty, FNL_RST_DUTY);
    chk({7'h00, entry_exceeded}, 8'h00);
    chk({7'h00, chain_active}, 8'h00);
    wr(FNL_OFS_LIMIT, 8'h11);
    rd(FNL_OFS_LIMIT, FNL_RST_LIMIT);
    rd(FNL_OFS_DUTY, FNL_RST_DUTY);
    $display("test reset and lock done");
    // Mode table: write, then read back the view of the current mode
    table_write_enable = 1'b1;
    foreach (rows[i])
    begin
      {thr, dhr, f22} = {rows[i].thr, rows[i].dhr, rows[i].f22};
      wr(rows[i].addr, rows[i].data);
      rd(rows[i].addr, rows[i].exp);
      chk({7'h00, reg_hit}, {7'h00, rows[i].hit});
    end
    $display("test mode table done");
    // Low resolution limit of 40 degrees, duty 0x15
    {thr, dhr, f22} = 3'b000;
    wr(FNL_OFS_LIMIT, 8'h28);
    wr(FNL_OFS_DUTY, 8'h15);
    settle();
    chk(pwm_duty, lo_duty);
    t_int = 8'd40;
    t_frac = 3'h4;
    settle();
    chk({7'h00, entry_exceeded}, 8'h00);
    t_int = 8'd41;
    t_frac = 3'h0;
    settle();
    chk({7'h00, entry_exceeded}, 8'h01);
    chk(pwm_duty, 8'h15);
    chk({7'h00, chain_active}, 8'h01);
    // Two degrees of hysteresis hold the entry until 38 or below
    hyst = 5'd2;
    t_int = 8'd39;
    settle();
    chk({7'h00, entry_exceeded}, 8'h01);
    t_int = 8'd37;
    settle();
    chk({7'h00, entry_exceeded}, 8'h00);
    // Offset of 10 raises the limit to 50
    ofs = 8'd10;
    t_int = 8'd45;
    settle();
    chk({7'h00, entry_exceeded}, 8'h00);
    t_int = 8'd51;
    settle();
    chk({7'h00, entry_exceeded}, 8'h01);
    $display("test low resolution compare done");
    // High resolution: limit 0x50 is 40.0, the half degree now counts
    {ofs, hyst, t_int} = '0;
    thr = 1'b1;
    wr(FNL_OFS_LIMIT, 8'h50);
    t_int = 8'd40;
    t_frac = 3'h4;
    settle();
    chk({7'h00, entry_exceeded}, 8'h01);
    hi_act = 1'b1;
    hi_duty = 8'h33;
    settle();
    chk(pwm_duty, 8'h33);
    // Limit 0xFF is 127.5, not a negative value
    hi_act = 1'b0;
    t_int = 8'd0;
    t_frac = 3'h0;
    settle();
    wr(FNL_OFS_LIMIT, 8'hFF);
    t_int = 8'd127;
    t_frac = 3'h4;
    settle();
    chk({7'h00, entry_exceeded}, 8'h00);
    $display("test high resolution compare done");
    // Extended duty bits reach the PWM output only at 22.5 kHz
    {dhr, f22} = 2'b11;
    wr(FNL_OFS_LIMIT, 8'h50);
    wr(FNL_OFS_DUTY, 8'hC7);
    settle();
    chk(pwm_duty, 8'hC7);
    f22 = 1'b0;
    settle();
    chk(pwm_duty, 8'h07);
    {dhr, f22} = 2'b01;
    settle();
    chk(pwm_duty, 8'h07);
    chk({7'h00, chain_active}, 8'h01);
    $display("test extended duty done");
    // Reset in mid-run brings back every reset value
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk(reg_rd_data, FNL_RD_UNMAPPED);
    chk(pwm_duty, FNL_RST_DUTY);
    chk({7'h00, entry_exceeded}, 8'h00);
    rd(FNL_OFS_DUTY, FNL_RST_DUTY);
    rd(FNL_OFS_LIMIT, FNL_RST_LIMIT);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule // fnl_entry_bench
